// ### core/hmsd_pkg.sv
// Constants and types shared by the headphone mode and short-detect control.
// Assumes a single 100 MHz clock domain.
package hmsd_pkg;
   localparam int          CLK_MHZ         = 100;
   localparam int          PROBE_NS        = 3000;
   localparam int          PROBE_CYC       = (PROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int          DEBOUNCE_MS     = 10;
   localparam int          DEBOUNCE_CYC    = DEBOUNCE_MS * CLK_MHZ * 1000;
   localparam logic [15:0] SHORT_LIMIT_MOHM = 16'h0FA0;
   localparam int          TEMP_TRIP_C     = 140;
   localparam int          TEMP_HYST_C     = 15;
   localparam logic [7:0]  TEMP_TRIP       = 8'(TEMP_TRIP_C);
   localparam logic [7:0]  TEMP_REARM      = 8'(TEMP_TRIP_C - TEMP_HYST_C);
   localparam logic        FAULT_IDLE      = 1'b1;

   typedef enum logic [1:0] {
      HMSD_MODE_OFF    = 2'b00,
      HMSD_MODE_MONO   = 2'b01,
      HMSD_MODE_STEREO = 2'b10,
      HMSD_MODE_AUTO   = 2'b11
   } hmsd_mode_t;

   typedef enum logic [2:0] {
      HMSD_IDLE  = 3'b000,
      HMSD_PROBE_L = 3'b001,
      HMSD_PROBE_R = 3'b010,
      HMSD_DECIDE  = 3'b011
   } hmsd_state_t;

   typedef enum logic [1:0] {
      HMSD_OUT_HIZ   = 2'b00,
      HMSD_OUT_DRIVE = 2'b01,
      HMSD_OUT_1K    = 2'b10
   } hmsd_out_t;
endpackage : hmsd_pkg

// ### core/hmsd_edge_sync.sv
// Two-flop synchroniser with rise and fall pulses on the clean value.
// Assumes the input may be asynchronous to clk.
`timescale 1ns/1ps
module hmsd_edge_sync (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic din,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic meta_q;
   logic sync_q;
   logic prev_q;

   // First flop feeds only the second
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Edge pulses from synchronised history, one per edge
   assign level = sync_q;
   assign rise  = sync_q & ~prev_q;
   assign fall  = ~sync_q & prev_q;
endmodule : hmsd_edge_sync

// ### core/hmsd_timer.sv
// Load-and-count-down timer giving a one-cycle done pulse.
// Assumes the loaded count is at least one.
`timescale 1ns/1ps
module hmsd_timer #(
   parameter int W = 32
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         load,
   input  wire logic         stop,
   input  wire logic [W-1:0] count,
   output logic              busy,
   output logic              done
);
   logic [W-1:0] cnt_q;
   logic         run_q;

   // Count down while running, halt on stop
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q <= '0;
         run_q <= 1'b0;
      end else if (stop) begin
         run_q <= 1'b0;
      end else if (load) begin
         cnt_q <= count;
         run_q <= 1'b1;
      end else if (run_q) begin
         cnt_q <= cnt_q - W'(1);
         run_q <= (cnt_q != W'(1));
      end
   end

   // Done ignores load, so a reload issued on done forms no loop
   assign busy = run_q;
   assign done = run_q & (cnt_q == W'(1)) & ~stop;
endmodule : hmsd_timer

// ### core/hmsd_ctrl.sv
// Mode decode, short-probe sequencer and fault latch of the headphone amp.
// Assumes analog sense comparators arrive as clk-synchronous levels.
//
// How it works
// - Rising edge on mode_sel_a with mode_sel_b high starts a probe run.
// - Falling edge on mode_sel_a releases the fault output to high.
// - Load below four ohms measured during a probe marks that side faulted.
// - One faulted side, auto or stereo mode: disable it, mix inputs halved onto healthy side.
// - Both sides faulted, auto or stereo mode: both outputs high impedance, audio muted.
// - Auto mode runs probe on jack, overcurrent, overtemp or power cycle.
// - Jack-sense rise waits a debounce delay before probing.
// - Both mode inputs low: shutdown, pullup off, pump off, 1k outputs.
// - Mono mode: right high impedance, mix on left, probing off.
// - Stereo mode: both channels stereo, probing off.
// - Fault output open-drain active low, latched until cleared.
// - Overtemperature cuts output stage; re-enabled after 15 C cooling.
// - Short found before stereo selected keeps mono operation.
// - Each load probed with a 3 us pulse and current sensed.
`timescale 1ns/1ps
module hmsd_ctrl
   import hmsd_pkg::*;
#(
   parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        mode_sel_a,
   input  wire logic        mode_sel_b,
   input  wire logic        jack_sense,
   input  wire logic        src_overcurrent,
   input  wire logic [15:0] load_mohm,
   input  wire logic [7:0]  die_temp_c,
   output logic             probe_pulse,
   output logic             probe_left,
   output logic             jack_pullup_en,
   output logic             pump_en,
   output logic [1:0]       left_out_state,
   output logic [1:0]       right_out_state,
   output logic             mix_en,
   output logic             left_in_to_left,
   output logic             right_in_to_right,
   output logic             fault_n_o,
   output logic             fault_n_oe,
   output logic             routine_busy
);
   logic        a_lvl, a_rise, a_fall;
   logic        b_lvl, b_rise, b_fall;
   logic        jack_q, oc_q;
   logic        hot_q;
   logic        off_q;
   logic        fault_q;
   logic        short_l_q, short_r_q;
   logic        left_bad_q, right_bad_q;
   hmsd_state_t state_q, state_d;
   logic        tmr_load, tmr_busy, tmr_done;
   logic        db_busy, db_done;
   logic [31:0] tmr_count;

   // Mode inputs synchronised, edges taken once
   hmsd_edge_sync u_sync_a (
      .clk   (clk),
      .nrst  (nrst),
      .din   (mode_sel_a),
      .level (a_lvl),
      .rise  (a_rise),
      .fall  (a_fall)
   );
   hmsd_edge_sync u_sync_b (
      .clk   (clk),
      .nrst  (nrst),
      .din   (mode_sel_b),
      .level (b_lvl),
      .rise  (b_rise),
      .fall  (b_fall)
   );

   // Mode decode
   hmsd_mode_t mode;
   assign mode = hmsd_mode_t'({b_lvl, a_lvl});
   wire is_off    = (mode == HMSD_MODE_OFF);
   wire is_mono   = (mode == HMSD_MODE_MONO);
   wire is_stereo = (mode == HMSD_MODE_STEREO);
   wire is_auto   = (mode == HMSD_MODE_AUTO);

   // Trigger sources
   wire jack_rise = jack_sense & ~jack_q;
   wire oc_rise   = src_overcurrent & ~oc_q;
   wire hot_set   = (die_temp_c > TEMP_TRIP);
   wire hot_clr   = (die_temp_c <= TEMP_REARM);
   wire hot_rise  = hot_set & ~hot_q;
   wire wake      = off_q & ~is_off;
   wire idle      = (state_q == HMSD_IDLE);
   wire trig_auto = is_auto & (oc_rise | hot_rise | wake | db_done);
   wire trig_host = a_rise & b_lvl;
   wire start     = idle & (trig_auto | trig_host);

   // Sense edge history, thermal hysteresis, shutdown memory
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         jack_q <= 1'b0;
         oc_q   <= 1'b0;
         hot_q  <= 1'b0;
         off_q  <= 1'b1;
      end else begin
         jack_q <= jack_sense;
         oc_q   <= src_overcurrent;
         hot_q  <= hot_set | (hot_q & ~hot_clr);
         off_q  <= is_off;
      end
   end

   // Jack debounce, restarted on every rise in auto mode, dropped if jack falls or auto mode is left
   hmsd_timer #(.W(32)) u_debounce (
      .clk   (clk),
      .nrst  (nrst),
      .load  (jack_rise & is_auto),
      .stop  (~jack_sense | ~is_auto),
      .count (32'(DEBOUNCE_CYCLES)),
      .busy  (db_busy),
      .done  (db_done)
   );

   // Probe pulse timer
   assign tmr_count = 32'(PROBE_CYC);
   hmsd_timer #(.W(32)) u_probe (
      .clk   (clk),
      .nrst  (nrst),
      .load  (tmr_load),
      .stop  (is_off),
      .count (tmr_count),
      .busy  (tmr_busy),
      .done  (tmr_done)
   );

   wire load_short = (load_mohm < SHORT_LIMIT_MOHM);

   // Probe sequencer: left pulse, right pulse, decide
   always_comb begin
      state_d  = state_q;
      tmr_load = 1'b0;
      case (state_q)
         HMSD_IDLE: begin
            if (start) begin
               state_d  = HMSD_PROBE_L;
               tmr_load = 1'b1;
            end
         end
         HMSD_PROBE_L: begin
            if (tmr_done) begin
               state_d  = HMSD_PROBE_R;
               tmr_load = 1'b1;
            end
         end
         HMSD_PROBE_R: begin
            if (tmr_done) begin
               state_d = HMSD_DECIDE;
            end
         end
         HMSD_DECIDE: state_d = HMSD_IDLE;
         default:     state_d = HMSD_IDLE;
      endcase
      if (is_off) begin
         state_d  = HMSD_IDLE;
         tmr_load = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= HMSD_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Current sensed at the end of each probe pulse
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         short_l_q <= 1'b0;
         short_r_q <= 1'b0;
      end else if (start) begin
         short_l_q <= 1'b0;
         short_r_q <= 1'b0;
      end else if (tmr_done && state_q == HMSD_PROBE_L) begin
         short_l_q <= load_short;
      end else if (tmr_done && state_q == HMSD_PROBE_R) begin
         short_r_q <= load_short;
      end
   end

   // Result held across modes; shutdown forgets it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         left_bad_q  <= 1'b0;
         right_bad_q <= 1'b0;
      end else if (is_off) begin
         left_bad_q  <= 1'b0;
         right_bad_q <= 1'b0;
      end else if (state_q == HMSD_DECIDE) begin
         left_bad_q  <= short_l_q;
         right_bad_q <= short_r_q;
      end
   end

   // Fault latch; a new detection wins over the clear edge
   wire found = (state_q == HMSD_DECIDE) & (short_l_q | short_r_q);
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fault_q <= 1'b0;
      end else if (found) begin
         fault_q <= 1'b1;
      end else if (a_fall) begin
         fault_q <= 1'b0;
      end
   end

   // Open-drain fault: drive low only when latched
   assign fault_n_o  = ~FAULT_IDLE;
   assign fault_n_oe = fault_q;

   // Output routing per mode and probe result
   wire any_bad   = left_bad_q | right_bad_q;
   wire both_bad  = left_bad_q & right_bad_q;
   wire auto_like = is_auto | (is_stereo & any_bad);
   // Forced mono ignores load results, so only auto-like modes mute
   wire mute      = auto_like & both_bad;
   wire l_on = ~hot_q & ~mute & (is_mono | is_stereo | is_auto)
               & ~(auto_like & left_bad_q);
   wire r_on = ~hot_q & ~mute & (is_stereo | is_auto)
               & ~(auto_like & right_bad_q);
   wire mono_mix = is_mono | (auto_like & any_bad & ~both_bad);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         left_out_state    <= HMSD_OUT_1K;
         right_out_state   <= HMSD_OUT_1K;
         mix_en            <= 1'b0;
         left_in_to_left   <= 1'b0;
         right_in_to_right <= 1'b0;
         jack_pullup_en    <= 1'b0;
         pump_en           <= 1'b0;
      end else if (is_off) begin
         left_out_state    <= HMSD_OUT_1K;
         right_out_state   <= HMSD_OUT_1K;
         mix_en            <= 1'b0;
         left_in_to_left   <= 1'b0;
         right_in_to_right <= 1'b0;
         jack_pullup_en    <= 1'b0;
         pump_en           <= 1'b0;
      end else begin
         left_out_state    <= l_on ? HMSD_OUT_DRIVE : HMSD_OUT_HIZ;
         right_out_state   <= r_on ? HMSD_OUT_DRIVE : HMSD_OUT_HIZ;
         mix_en            <= mono_mix & ~mute;
         left_in_to_left   <= l_on & ~mono_mix;
         right_in_to_right <= r_on & ~mono_mix;
         jack_pullup_en    <= 1'b1;
         pump_en           <= 1'b1;
      end
   end

   // Probe drive to the analog side
   assign probe_pulse  = tmr_busy & (state_q == HMSD_PROBE_L
                                    || state_q == HMSD_PROBE_R);
   assign probe_left   = (state_q == HMSD_PROBE_L);
   assign routine_busy = ~idle;

   // Assertions
   property p_rerun;
      @(posedge clk) disable iff (!nrst)
      (idle && a_rise && b_lvl) |=> (state_q == HMSD_PROBE_L);
   endproperty
   a_rerun: assert property (p_rerun) else $error("rerun not started");

   property p_clear;
      @(posedge clk) disable iff (!nrst)
      (a_fall && !found) |=> !fault_n_oe;
   endproperty
   a_clear: assert property (p_clear) else $error("fault not cleared");

   property p_probe_len;
      @(posedge clk) disable iff (!nrst)
      $rose(probe_pulse) && !is_off |-> probe_pulse [*8] ##1 probe_pulse;
   endproperty
   a_probe_len: assert property (p_probe_len)
      else $error("probe pulse too short");

   property p_latch;
      @(posedge clk) disable iff (!nrst)
      found |=> fault_n_oe;
   endproperty
   a_latch: assert property (p_latch) else $error("fault not latched");

   property p_both;
      @(posedge clk) disable iff (!nrst)
      (both_bad && (is_auto || is_stereo)) |=> (left_out_state == HMSD_OUT_HIZ
                                && right_out_state == HMSD_OUT_HIZ
                                && !mix_en);
   endproperty
   a_both: assert property (p_both) else $error("both shorted not muted");

   property p_shutdown;
      @(posedge clk) disable iff (!nrst)
      is_off |=> (!pump_en && !jack_pullup_en
                  && left_out_state == HMSD_OUT_1K);
   endproperty
   a_shutdown: assert property (p_shutdown)
      else $error("shutdown not applied");

   property p_mono;
      @(posedge clk) disable iff (!nrst)
      (is_mono && !hot_q) |=> (right_out_state == HMSD_OUT_HIZ && mix_en);
   endproperty
   a_mono: assert property (p_mono) else $error("mono routing wrong");

   property p_no_probe_forced;
      @(posedge clk) disable iff (!nrst)
      (idle && (is_mono || (is_stereo && !a_rise))) |=> idle;
   endproperty
   a_no_probe_forced: assert property (p_no_probe_forced)
      else $error("probe in forced mode");

   property p_hot;
      @(posedge clk) disable iff (!nrst)
      (hot_q && !is_off) |=> (left_out_state == HMSD_OUT_HIZ);
   endproperty
   a_hot: assert property (p_hot) else $error("hot stage not off");

   c_run:   cover property (@(posedge clk) state_q == HMSD_DECIDE);
   c_fault: cover property (@(posedge clk) found);
   c_clear: cover property (@(posedge clk) fault_q ##1 !fault_q);
   c_jack:  cover property (@(posedge clk) db_done);
endmodule : hmsd_ctrl

// ### sim/hmsd_host.sv
// Host controller model: drives both mode inputs, reads the fault line.
// Assumes the fault line is already resolved with its pull-up.
`timescale 1ns/1ps
module hmsd_host (
   input  wire logic clk,
   input  wire logic fault_line,
   output logic      mode_sel_a,
   output logic      mode_sel_b
);
   // Power up in automatic mode
   initial begin
      mode_sel_a = 1'b1;
      mode_sel_b = 1'b1;
   end

   // Change both pins after an edge, then let the sync settle
   task automatic set_mode(input logic a, input logic b);
      @(posedge clk);
      mode_sel_a <= a;
      mode_sel_b <= b;
      repeat (8) @(posedge clk);
      #1;
   endtask : set_mode

   // Rerun only while a fault is flagged, to avoid a transient
   task automatic rerun;
      if (fault_line === 1'b0) begin
         set_mode(1'b0, 1'b1);
         set_mode(1'b1, 1'b1);
      end
   endtask : rerun
endmodule : hmsd_host

// ### sim/tb.sv
// Self-checking bench for the mode and short-detect control.
// Assumes a host model on the mode pins and a pulled-up fault line.
`timescale 1ns/1ps
module tb;
   import hmsd_pkg::*;
   logic        clk, nrst, jack_sense, src_ovc;
   logic [15:0] load_mohm, l_ld, r_ld;
   logic [7:0]  die_temp_c;
   logic        mode_sel_a, mode_sel_b;
   logic        probe_pulse, probe_left, pullup_en, pump_en;
   logic [1:0]  l_st, r_st;
   logic        mix_en, l2l, r2r, fault_n_o, fault_n_oe, busy;
   int          err_total, compares, lc, rc;
   wire         fault_line = fault_n_oe ? fault_n_o : 1'b1;

   hmsd_ctrl #(.DEBOUNCE_CYCLES(20)) uut (
      .clk(clk), .nrst(nrst), .mode_sel_a(mode_sel_a),
      .mode_sel_b(mode_sel_b), .jack_sense(jack_sense),
      .src_overcurrent(src_ovc), .load_mohm(load_mohm),
      .die_temp_c(die_temp_c), .probe_pulse(probe_pulse),
      .probe_left(probe_left), .jack_pullup_en(pullup_en),
      .pump_en(pump_en), .left_out_state(l_st), .right_out_state(r_st),
      .mix_en(mix_en), .left_in_to_left(l2l), .right_in_to_right(r2r),
      .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe),
      .routine_busy(busy));
   hmsd_host host (.clk(clk), .fault_line(fault_line),
      .mode_sel_a(mode_sel_a), .mode_sel_b(mode_sel_b));

   // Clock and load model: each side shows its own load while probed
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      load_mohm <= probe_left ? l_ld : r_ld;
      if (probe_pulse && probe_left) lc++;
      else if (probe_pulse) rc++;
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   // Wait for one probe run to start and finish, bounded
   task automatic run_wait;
      int i;
      i = 0;
      while (busy !== 1'b1 && i < 60) begin cyc(1); i++; end
      chk(busy, 1'b1);
      i = 0;
      while (busy !== 1'b0 && i < 1000) begin cyc(1); i++; end
      chk(busy, 1'b0);
      cyc(4);
   endtask : run_wait

   task automatic stop_test;
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : stop_test

   // Power-up probe with left just under the limit, right at it
   task automatic t_power;
      run_wait();
      chk(lc, PROBE_CYC);
      chk(rc, PROBE_CYC);
      chk(l_st, HMSD_OUT_HIZ);
      chk(r_st, HMSD_OUT_DRIVE);
      chk(mix_en, 1'b1);
      chk(fault_line, 1'b0);
      cyc(30);
      chk(fault_line, 1'b0);
   endtask : t_power

   // Falling mode A clears fault; stereo keeps mono after a short
   task automatic t_clear;
      host.set_mode(1'b0, 1'b1);
      chk(fault_line, 1'b1);
      chk(mix_en, 1'b1);
      chk(l_st, HMSD_OUT_HIZ);
      host.set_mode(1'b1, 1'b1);
      run_wait();
      chk(fault_line, 1'b0);
   endtask : t_clear

   // Host rerun with both sides shorted
   task automatic t_both;
      l_ld <= 16'h0001;
      r_ld <= 16'h0FA0 - 16'h0001;
      host.rerun();
      run_wait();
      chk(l_st, HMSD_OUT_HIZ);
      chk(r_st, HMSD_OUT_HIZ);
      chk(fault_line, 1'b0);
      cyc(20);
      chk(busy, 1'b0);
   endtask : t_both

   // Forced modes, then auto entry with healthy loads
   task automatic t_modes;
      l_ld <= 16'h1388;
      r_ld <= 16'h1388;
      host.set_mode(1'b0, 1'b0);
      chk({pump_en, pullup_en}, 2'b00);
      chk({l_st, r_st}, {HMSD_OUT_1K, HMSD_OUT_1K});
      chk(fault_line, 1'b1);
      host.set_mode(1'b1, 1'b0);
      chk({l_st, r_st}, {HMSD_OUT_DRIVE, HMSD_OUT_HIZ});
      chk({mix_en, busy}, 2'b10);
      host.set_mode(1'b0, 1'b1);
      chk({l_st, r_st}, {HMSD_OUT_DRIVE, HMSD_OUT_DRIVE});
      chk({mix_en, l2l, r2r, busy}, 4'h6);
      host.set_mode(1'b1, 1'b1);
      run_wait();
      chk({l_st, r_st}, {HMSD_OUT_DRIVE, HMSD_OUT_DRIVE});
      chk({pump_en, fault_line}, 2'b11);
   endtask : t_modes

   // Jack insertion waits out the debounce, then overcurrent
   task automatic t_trig;
      @(posedge clk) jack_sense <= 1'b1;
      cyc(15);
      chk(busy, 1'b0);
      run_wait();
      @(posedge clk) jack_sense <= 1'b0;
      @(posedge clk) src_ovc <= 1'b1;
      @(posedge clk) src_ovc <= 1'b0;
      run_wait();
      chk(mix_en, 1'b0);
   endtask : t_trig

   // Overtemperature cuts outputs until cooled by the hysteresis
   task automatic t_therm;
      @(posedge clk) die_temp_c <= 8'h8D;
      run_wait();
      chk(l_st, HMSD_OUT_HIZ);
      @(posedge clk) die_temp_c <= 8'h7E;
      cyc(8);
      chk(r_st, HMSD_OUT_HIZ);
      @(posedge clk) die_temp_c <= 8'h7D;
      cyc(8);
      chk({l_st, r_st}, {HMSD_OUT_DRIVE, HMSD_OUT_DRIVE});
   endtask : t_therm

   // Main sequence
   initial begin
      err_total = 0;
      compares = 0;
      nrst = 1'b0;
      jack_sense = 1'b0;
      src_ovc = 1'b0;
      die_temp_c = 8'h19;
      l_ld = 16'h0F9F;
      r_ld = 16'h0FA0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      t_power();
      t_clear();
      t_both();
      t_modes();
      t_trig();
      t_therm();
      stop_test();
   end

   // Watchdog: the run needs well under 10000 cycles
   initial begin
      #200000;
      err_total++;
      stop_test();
   end
endmodule : tb
